//--- hw/telegram_pkg.sv
// shared constants, parameter lookup and config opcodes for the cyclic telegram decoder
package telegram_pkg;

  localparam int MAX_ENTRIES  = 10;
  localparam int NUM_LAYOUTS  = 4;
  localparam int NUM_TABLES   = 2 * NUM_LAYOUTS;

  localparam logic [5:0] ID_POS      = 6'h00;
  localparam logic [5:0] FIRST_POS   = 6'h01;
  localparam logic [5:0] FIXED_LO    = 6'h02;
  localparam logic [5:0] FIXED_HI    = 6'h03;
  localparam logic [1:0] FREE_LAYOUT = 2'h3;

  // arbitrary identifier bases; the low two bits carry the layout number
  localparam logic [7:0] RX_ID_BASE = 8'hE0;
  localparam logic [7:0] TX_ID_BASE = 8'hF0;

  localparam logic [1:0] MODE_POSITION = 2'h0;
  localparam logic [1:0] MODE_VELOCITY = 2'h1;
  localparam logic [1:0] MODE_TORQUE   = 2'h2;
  localparam logic [1:0] MODE_RESET    = 2'h0;

  localparam logic [1:0] OP_QUERY  = 2'h0;
  localparam logic [1:0] OP_APPEND = 2'h1;
  localparam logic [1:0] OP_DELETE = 2'h2;
  localparam logic [1:0] OP_SELECT = 2'h3;

  localparam logic [15:0] PN_CONTROL = 16'h03C7;
  localparam logic [15:0] PN_STATUS  = 16'h03C8;

  typedef struct packed {
    logic       exists;
    logic       writable;
    logic       readable;
    logic [2:0] size;
  } param_info_type;

  // parameter directory known to the drive; unknown numbers report exists = 0
  function automatic param_info_type param_info(input logic [15:0] pn);
    param_info_type r;
    r = '0;
    case (pn)
      16'h07DA: r = '{1'b1, 1'b1, 1'b0, 3'h1};
      16'h03C7: r = '{1'b1, 1'b1, 1'b0, 3'h2};
      16'h03C8: r = '{1'b1, 1'b0, 1'b1, 3'h2};
      16'h03E9: r = '{1'b1, 1'b1, 1'b1, 3'h4};
      16'h044C: r = '{1'b1, 1'b0, 1'b1, 3'h4};
      16'h044D: r = '{1'b1, 1'b0, 1'b1, 3'h4};
      16'h044E: r = '{1'b1, 1'b0, 1'b1, 3'h4};
      16'h0475: r = '{1'b1, 1'b0, 1'b1, 3'h4};
      16'h05DC: r = '{1'b1, 1'b1, 1'b1, 3'h1};
      default:  r = '0;
    endcase
    return r;
  endfunction

endpackage

//--- hw/word_buffer.sv
// shift-register buffer with valid/ready on both sides; head word always in slot 0
`timescale 1ns/10ps
module word_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] slot_q [DEPTH];
  logic [CW-1:0]    count_q;
  logic [CW-1:0]    count_d;
  logic             in_ready_q;
  logic             out_valid_q;
  logic             push;
  logic             pop;

  assign in_ready  = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data  = slot_q[0];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + CW'(1);
    end else if (pop && !push) begin
      count_d = count_q - CW'(1);
    end
  end

  // both handshake flags are registered from the next count so they leave flops directly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q     <= '0;
      in_ready_q  <= 1'b1;
      out_valid_q <= 1'b0;
    end else begin
      count_q     <= count_d;
      in_ready_q  <= (count_d != CW'(DEPTH));
      out_valid_q <= (count_d != '0);
    end
  end

  // a pop shifts every slot down; a simultaneous push lands in the old top slot, count_q - 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        slot_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (pop) begin
          if (push && CW'(i + 1) == count_q) begin
            slot_q[i] <= in_data;
          end else if (i < DEPTH - 1) begin
            slot_q[i] <= slot_q[(i + 1 < DEPTH) ? i + 1 : i];
          end
        end else if (push && CW'(i) == count_q) begin
          slot_q[i] <= in_data;
        end
      end
    end
  end
endmodule

//--- hw/cyclic_telegram_decoder.sv
// receive telegram decoder: layout tables, identifier dispatch, mode binding and entry extraction
`timescale 1ns/10ps
// What this block does
// [RL1] every layout, receive or response, holds at most ten entries; more are refused
// [RL2] byte zero is the identifier; it picks the layout used for the remaining bytes
// [RL3] receive layouts zero to two carry the control word at bytes two and three
// [RL4] four receive layouts exist, each with its own entry list
// [RL5] layout zero means positioning, one velocity; two and three bind no mode
// [RL6] a bound layout's identifier switches the mode if it differs
// [RL7] entries follow the header in configured order; total size must match
// [RL8] read-only parameters are refused as receive entries
// [RL9] each receive layout points at a chosen response layout, sharing allowed
// [RL10] an entry request reports whether the parameter exists and its byte size
// [RL11] multi-byte fields arrive least significant byte first
// [RL12] response layouts zero to two hold the status word at bytes two and three
// [RL13] an unknown identifier drops the telegram; mode and parameters stay unchanged
module cyclic_telegram_decoder
  import telegram_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_last,
  output logic             rx_ready,
  input  wire logic        cfg_valid,
  input  wire logic [1:0]  cfg_op,
  input  wire logic        cfg_resp,
  input  wire logic [1:0]  cfg_layout,
  input  wire logic [15:0] cfg_param,
  input  wire logic [1:0]  cfg_target,
  output logic             cfg_done,
  output logic             cfg_ok,
  output logic [2:0]       cfg_size,
  output logic [5:0]       cfg_offset,
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic [15:0]      wr_param,
  output logic [31:0]      wr_value,
  output logic [2:0]       wr_size,
  output logic [15:0]      ctrl_word,
  output logic             ctrl_update,
  output logic [1:0]       mode,
  output logic             mode_change,
  output logic [1:0]       resp_layout,
  output logic [7:0]       resp_id,
  output logic             telegram_done,
  output logic             telegram_drop,
  output logic             size_error
);
  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_DROP} state_type;
  // layout tables: index {response, layout}
  logic [15:0] ent_param_q [NUM_TABLES][MAX_ENTRIES];
  logic [2:0]  ent_size_q  [NUM_TABLES][MAX_ENTRIES];
  logic [3:0]  cnt_q       [NUM_TABLES];
  logic [5:0]  len_q       [NUM_TABLES];
  logic [1:0]  resp_sel_q  [NUM_LAYOUTS];
  state_type   state_q;
  logic [1:0]  lay_q;
  logic [5:0]  pos_q;
  logic [3:0]  idx_q;
  logic [2:0]  byte_q;
  logic [31:0] acc_q;
  logic [7:0]  ctrl_lo_q;
  logic           cfg_done_q, cfg_ok_q;
  logic [2:0]     cfg_size_q;
  logic [5:0]     cfg_offset_q;
  logic [15:0]    ctrl_word_q;
  logic           ctrl_update_q;
  logic [1:0]     mode_q;
  logic           mode_change_q;
  logic [1:0]     resp_layout_q;
  logic [7:0]     resp_id_q;
  logic           done_q, drop_q, size_err_q;
  // configuration request decode
  logic [2:0]     ci;
  param_info_type info;
  logic [5:0]     off;
  logic           covers_fixed;
  logic           hdr_ok;
  logic           dir_ok;
  logic           append_ok;
  logic [15:0]    fixed_pn;
  logic [3:0]     last_i;
  assign ci       = {cfg_resp, cfg_layout};
  assign info     = param_info(cfg_param);
  assign off      = len_q[ci];
  assign fixed_pn = cfg_resp ? PN_STATUS : PN_CONTROL;
  assign last_i   = cnt_q[ci] - 4'h1;
  assign covers_fixed = (off <= FIXED_LO) && ((off + {3'h0, info.size}) > FIXED_LO);
  // outside layout three the control or status word must sit exactly at bytes two and three, nowhere else
  assign hdr_ok   = (cfg_layout == FREE_LAYOUT) ||                                 // [RL3] [RL12]
                    (covers_fixed ? (cfg_param == fixed_pn && off == FIXED_LO) : (cfg_param != fixed_pn));
  assign dir_ok   = cfg_resp ? info.readable : info.writable;                     // [RL8]
  assign append_ok = info.exists && (cnt_q[ci] < 4'(MAX_ENTRIES)) && dir_ok && hdr_ok; // [RL1]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int t = 0; t < NUM_TABLES; t++) begin
        cnt_q[t] <= '0;
        len_q[t] <= FIRST_POS;
        for (int e = 0; e < MAX_ENTRIES; e++) begin
          ent_param_q[t][e] <= '0;
          ent_size_q[t][e]  <= '0;
        end
      end
    end else if (cfg_valid && cfg_op == OP_APPEND && append_ok) begin
      ent_param_q[ci][cnt_q[ci]] <= cfg_param;                                    // [RL4] [RL7]
      ent_size_q[ci][cnt_q[ci]]  <= info.size;
      cnt_q[ci] <= cnt_q[ci] + 4'h1;
      len_q[ci] <= off + {3'h0, info.size};
    end else if (cfg_valid && cfg_op == OP_DELETE && cnt_q[ci] != 4'h0) begin
      cnt_q[ci] <= last_i;
      len_q[ci] <= off - {3'h0, ent_size_q[ci][last_i]};
    end
  end
  // by default each receive layout answers with the response layout of the same number
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int l = 0; l < NUM_LAYOUTS; l++) begin
        resp_sel_q[l] <= 2'(l);
      end
    end else if (cfg_valid && cfg_op == OP_SELECT && !cfg_resp) begin
      resp_sel_q[cfg_layout] <= cfg_target;                                       // [RL9]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_done_q   <= 1'b0;
      cfg_ok_q     <= 1'b0;
      cfg_size_q   <= '0;
      cfg_offset_q <= '0;
    end else begin
      cfg_done_q <= cfg_valid;
      if (cfg_valid) begin
        cfg_size_q   <= info.size;                                                // [RL10]
        cfg_offset_q <= off;
        case (cfg_op)
          OP_QUERY:  cfg_ok_q <= info.exists;                                     // [RL10]
          OP_APPEND: cfg_ok_q <= append_ok;
          OP_DELETE: begin
            cfg_ok_q     <= (cnt_q[ci] != 4'h0);
            cfg_offset_q <= (cnt_q[ci] != 4'h0) ? off - {3'h0, ent_size_q[ci][last_i]} : off;
          end
          default:   cfg_ok_q <= !cfg_resp;
        endcase
      end
    end
  end
  // telegram datapath
  logic        accept;
  logic        id_match;
  logic [2:0]  li;
  logic [2:0]  cur_size;
  logic [15:0] cur_param;
  logic        in_entry;
  logic [31:0] acc_n;
  logic        push;
  logic        buf_ready;
  logic        len_ok;
  assign rx_ready  = buf_ready;
  assign accept    = rx_valid && buf_ready;
  assign id_match  = (rx_data[7:2] == RX_ID_BASE[7:2]) && (cnt_q[{1'b0, rx_data[1:0]}] != 4'h0); // [RL2] [RL13]
  assign li        = {1'b0, lay_q};
  assign in_entry  = idx_q < cnt_q[li];
  assign cur_param = ent_param_q[li][in_entry ? idx_q : 4'h0];
  assign cur_size  = ent_size_q[li][in_entry ? idx_q : 4'h0];
  assign acc_n     = acc_q | ({24'h0, rx_data} << {byte_q, 3'b000});              // [RL11]
  assign push      = accept && state_q == ST_DATA && in_entry && (byte_q == cur_size - 3'h1);
  assign len_ok    = (pos_q + 6'h1) == len_q[li];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      lay_q   <= '0;
      pos_q   <= ID_POS;
      idx_q   <= '0;
      byte_q  <= '0;
      acc_q   <= '0;
    end else if (accept) begin
      case (state_q)
        ST_IDLE: begin
          lay_q  <= rx_data[1:0];
          pos_q  <= FIRST_POS;
          idx_q  <= '0;
          byte_q <= '0;
          acc_q  <= '0;
          if (!rx_last) begin
            state_q <= id_match ? ST_DATA : ST_DROP;                              // [RL13]
          end
        end
        ST_DATA: begin
          pos_q <= pos_q + 6'h1;
          if (push) begin
            idx_q  <= idx_q + 4'h1;                                               // [RL7]
            byte_q <= '0;
            acc_q  <= '0;
          end else if (in_entry) begin
            byte_q <= byte_q + 3'h1;
            acc_q  <= acc_n;
          end
          if (rx_last) begin
            state_q <= ST_IDLE;
          end
        end
        ST_DROP: begin
          if (rx_last) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // only the two bound layouts touch the mode; a switch is raised once per change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q        <= MODE_RESET;
      mode_change_q <= 1'b0;
      resp_layout_q <= '0;
      resp_id_q     <= TX_ID_BASE;
    end else begin
      mode_change_q <= 1'b0;
      if (accept && state_q == ST_IDLE && id_match) begin
        resp_layout_q <= resp_sel_q[rx_data[1:0]];                                // [RL9]
        resp_id_q     <= TX_ID_BASE | {6'h00, resp_sel_q[rx_data[1:0]]};
        if (rx_data[1:0] == 2'h0 && mode_q != MODE_POSITION) begin                // [RL5] [RL6]
          mode_q        <= MODE_POSITION;
          mode_change_q <= 1'b1;
        end else if (rx_data[1:0] == 2'h1 && mode_q != MODE_VELOCITY) begin
          mode_q        <= MODE_VELOCITY;
          mode_change_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_lo_q     <= '0;
      ctrl_word_q   <= '0;
      ctrl_update_q <= 1'b0;
    end else begin
      ctrl_update_q <= 1'b0;
      if (accept && state_q == ST_DATA && lay_q != FREE_LAYOUT) begin
        if (pos_q == FIXED_LO) begin
          ctrl_lo_q <= rx_data;                                                   // [RL3] [RL11]
        end else if (pos_q == FIXED_HI) begin
          ctrl_word_q   <= {rx_data, ctrl_lo_q};
          ctrl_update_q <= 1'b1;
        end
      end
    end
  end
  // short or long telegrams are flagged; entries already complete are not recalled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q     <= 1'b0;
      drop_q     <= 1'b0;
      size_err_q <= 1'b0;
    end else begin
      done_q     <= 1'b0;
      drop_q     <= 1'b0;
      size_err_q <= 1'b0;
      if (accept && state_q == ST_IDLE) begin
        drop_q <= !id_match;                                                      // [RL13]
        if (id_match && rx_last) begin
          done_q     <= len_q[{1'b0, rx_data[1:0]}] == FIRST_POS;
          size_err_q <= len_q[{1'b0, rx_data[1:0]}] != FIRST_POS;
        end
      end else if (accept && state_q == ST_DATA && rx_last) begin
        done_q     <= len_ok;
        size_err_q <= !len_ok;                                                    // [RL7]
      end
    end
  end
  word_buffer #(
    .WIDTH (51),
    .DEPTH (BUF_DEPTH)
  ) u_buffer (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_data   ({cur_param, acc_n, cur_size}),
    .in_ready  (buf_ready),
    .out_valid (wr_valid),
    .out_data  ({wr_param, wr_value, wr_size}),
    .out_ready (wr_ready)
  );
  assign cfg_done      = cfg_done_q;
  assign cfg_ok        = cfg_ok_q;
  assign cfg_size      = cfg_size_q;
  assign cfg_offset    = cfg_offset_q;
  assign ctrl_word     = ctrl_word_q;
  assign ctrl_update   = ctrl_update_q;
  assign mode          = mode_q;
  assign mode_change   = mode_change_q;
  assign resp_layout   = resp_layout_q;
  assign resp_id       = resp_id_q;
  assign telegram_done = done_q;
  assign telegram_drop = drop_q;
  assign size_error    = size_err_q;
  a_entry_limit: assert property (@(posedge clk) disable iff (!rst_n)                     // [RL1]
    cfg_valid && cfg_op == OP_APPEND && cnt_q[ci] == 4'(MAX_ENTRIES) |=> cfg_done && !cfg_ok)
    else $error("append accepted on a full layout");
  a_unknown_drop: assert property (@(posedge clk) disable iff (!rst_n)                    // [RL13]
    accept && state_q == ST_IDLE && !id_match |=> telegram_drop && $stable(mode) && state_q != ST_DATA)
    else $error("unknown identifier not dropped");
  a_bound_mode: assert property (@(posedge clk) disable iff (!rst_n)                      // [RL6]
    accept && state_q == ST_IDLE && id_match && rx_data[1:0] == 2'h1 |=> mode == MODE_VELOCITY)
    else $error("velocity layout did not set velocity mode");
  a_unbound_mode: assert property (@(posedge clk) disable iff (!rst_n)                    // [RL5]
    accept && state_q == ST_IDLE && id_match && rx_data[1] |=> $stable(mode) && !mode_change)
    else $error("unbound layout changed the mode");
  a_ctrl_word: assert property (@(posedge clk) disable iff (!rst_n)                       // [RL3]
    accept && state_q == ST_DATA && lay_q != FREE_LAYOUT && pos_q == FIXED_HI
      |=> ctrl_update && ctrl_word[15:8] == $past(rx_data) && ctrl_word[7:0] == $past(ctrl_lo_q))
    else $error("control word not taken from bytes two and three");
  a_readonly_refused: assert property (@(posedge clk) disable iff (!rst_n)                // [RL8]
    cfg_valid && cfg_op == OP_APPEND && !cfg_resp && !info.writable
      |=> !cfg_ok && cnt_q[$past(ci)] == $past(cnt_q[ci]))
    else $error("read-only parameter accepted for receive layout");
  a_size_report: assert property (@(posedge clk) disable iff (!rst_n)                     // [RL10]
    cfg_valid && cfg_op == OP_QUERY |=> cfg_ok == $past(info.exists) && cfg_size == $past(info.size))
    else $error("query answer wrong");
  a_lsb_first: assert property (@(posedge clk) disable iff (!rst_n)                       // [RL11]
    push && cur_size == 3'h2 |-> acc_n[15:8] == rx_data && acc_n[7:0] == acc_q[7:0])
    else $error("two-byte field not assembled low byte first");
  a_status_place: assert property (@(posedge clk) disable iff (!rst_n)                    // [RL12]
    cfg_valid && cfg_op == OP_APPEND && cfg_resp && cfg_layout != FREE_LAYOUT && off == FIXED_LO
      && cfg_param != PN_STATUS |=> !cfg_ok)
    else $error("status word slot given to another parameter");
  a_resp_pair: assert property (@(posedge clk) disable iff (!rst_n)                       // [RL9]
    cfg_valid && cfg_op == OP_SELECT && !cfg_resp |=> resp_sel_q[$past(cfg_layout)] == $past(cfg_target))
    else $error("response layout selection not stored");
  a_size_check: assert property (@(posedge clk) disable iff (!rst_n)                      // [RL7]
    accept && state_q == ST_DATA && rx_last && !len_ok |=> size_error && !telegram_done)
    else $error("wrong telegram length not flagged");
endmodule

//--- tb/telegram_master.sv
// fieldbus master model: streams one telegram byte by byte, prompt or with gaps
`timescale 1ns/10ps
module telegram_master (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic         slow,
  input  wire logic [127:0] frame,
  input  wire logic [4:0]   len,
  input  wire logic         rx_ready,
  output logic              busy,
  output logic              rx_valid,
  output logic              rx_last,
  output logic [7:0]        rx_data
);
  logic [4:0] idx;
  logic       took;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      took <= 1'b0;
    end else begin
      took <= rx_valid & rx_ready;
    end
  end

  // identifier first, then entries in configured order, low byte first
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {busy, rx_valid, rx_last, idx} <= '0;
      rx_data <= 8'h00;
    end else if (rx_valid && took) begin
      idx <= idx + 5'd1;
      busy <= !rx_last;
      if (rx_last || slow) begin
        // released line shows the inverse so a stale byte never passes for data
        rx_data <= ~rx_data;
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
      end else begin
        rx_data <= frame[8*(idx+5'd1)+:8];
        rx_last <= (idx + 5'd2 == len);
      end
    end else if (busy && !rx_valid) begin
      rx_valid <= 1'b1;
      rx_data <= frame[8*idx+:8];
      rx_last <= (idx + 5'd1 == len);
    end else if (start && !busy) begin
      busy <= 1'b1;
      idx <= 5'd0;
    end
  end
endmodule

//--- tb/cyclic_telegram_decoder_tb.sv
// self-checking bench for the cyclic telegram decoder driven by a master model
`timescale 1ns/10ps
module cyclic_telegram_decoder_tb;
  import telegram_pkg::*;
  logic         clk, rst_n, cfg_valid, cfg_resp, wr_ready, start, slow, busy;
  logic         rx_valid, rx_last, rx_ready, cfg_done, cfg_ok, wr_valid, ctrl_update;
  logic         mode_change, telegram_done, telegram_drop, size_error;
  logic [1:0]   cfg_op, cfg_layout, cfg_target, mode, resp_layout;
  logic [2:0]   cfg_size, wr_size;
  logic [4:0]   len;
  logic [5:0]   cfg_offset;
  logic [7:0]   rx_data, resp_id;
  logic [15:0]  cfg_param, wr_param, ctrl_word;
  logic [31:0]  wr_value;
  logic [127:0] frame;
  logic [47:0]  got[$], want[$];
  int           n_fail, check_count, n_done, n_drop, n_size, n_mode, n_ctrl;

  cyclic_telegram_decoder DUT (.*);
  telegram_master master (.*);

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (rst_n) begin
      n_done += (telegram_done === 1'b1);
      n_drop += (telegram_drop === 1'b1);
      n_size += (size_error === 1'b1);
      n_mode += (mode_change === 1'b1);
      n_ctrl += (ctrl_update === 1'b1);
      if (wr_valid === 1'b1 && wr_ready === 1'b1) got.push_back({wr_param, wr_value});
    end
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      n_fail++;
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // pn carries the target layout for a select; arg is the size for a query, else the offset
  task automatic cfg(input logic [1:0] op, input logic rs, input logic [1:0] lay, input logic [15:0] pn,
                     input logic ok, input logic [5:0] arg);
    @(negedge clk);
    {cfg_valid, cfg_op, cfg_resp, cfg_layout, cfg_param, cfg_target} = {1'b1, op, rs, lay, pn, pn[1:0]};
    @(negedge clk);
    cfg_valid = 1'b0;
    check(cfg_done, 1'b1);
    check(cfg_ok, ok);
    if (op == OP_QUERY) check(cfg_size, arg[2:0]);
    else if (ok && op != OP_SELECT) check(cfg_offset, arg);
  endtask

  task automatic wait_busy(input logic v);
    for (int k = 0; busy !== v; k++) begin
      if (k == 400) begin
        n_fail++;
        close_out;
      end
      @(posedge clk);
    end
  endtask

  task automatic send(input logic [7:0] b[$], input logic s);
    @(negedge clk);
    frame = '0;
    foreach (b[i]) frame[8*i+:8] = b[i];
    len = 5'(b.size());
    slow = s;
    start <= 1'b1;
    wait_busy(1'b1);
    @(negedge clk);
    start <= 1'b0;
  endtask

  task automatic finish_frame;
    wait_busy(1'b0);
    repeat (3) @(posedge clk);
    check(got.size(), want.size());
    foreach (want[i]) check(got[i], want[i]);
  endtask

  task automatic scn_config;
    cfg(OP_QUERY, 0, 0, 16'h1234, 0, 6'h00);
    cfg(OP_QUERY, 0, 0, 16'h03E9, 1, 6'h04);
    cfg(OP_APPEND, 0, 0, 16'h07DA, 1, 6'h01);
    cfg(OP_APPEND, 0, 0, 16'h03E9, 0, 6'h00);
    cfg(OP_APPEND, 0, 0, 16'h03C8, 0, 6'h00);
    cfg(OP_APPEND, 0, 0, 16'h03C7, 1, 6'h02);
    cfg(OP_APPEND, 0, 0, 16'h03E9, 1, 6'h04);
    cfg(OP_APPEND, 0, 1, 16'h07DA, 1, 6'h01);
    cfg(OP_APPEND, 0, 1, 16'h03C7, 1, 6'h02);
    cfg(OP_APPEND, 0, 1, 16'h05DC, 1, 6'h04);
    cfg(OP_SELECT, 1, 1, 16'h0002, 0, 6'h00);
    cfg(OP_SELECT, 0, 1, 16'h0002, 1, 6'h00);
    cfg(OP_APPEND, 1, 0, 16'h05DC, 1, 6'h01);
    cfg(OP_APPEND, 1, 0, 16'h07DA, 0, 6'h00);
    cfg(OP_APPEND, 1, 0, 16'h03C8, 1, 6'h02);
    for (int i = 0; i < 11; i++) cfg(OP_APPEND, 0, 3, 16'h05DC, i < 10, 6'(i + 1));
    cfg(OP_DELETE, 0, 3, 16'h0000, 1, 6'h0A);
    cfg(OP_APPEND, 0, 3, 16'h05DC, 1, 6'h0A);
    cfg(OP_DELETE, 0, 2, 16'h0000, 0, 6'h00);
  endtask

  task automatic scn_frames;
    // slow master on the velocity layout: mode switch and response choice follow the identifier
    want.push_back({16'h07DA, 32'h11});
    want.push_back({16'h03C7, 32'hABCD});
    want.push_back({16'h05DC, 32'h22});
    send('{8'hE1, 8'h11, 8'hCD, 8'hAB, 8'h22}, 1'b1);
    finish_frame;
    check({mode, resp_layout, resp_id}, {MODE_VELOCITY, 2'h2, TX_ID_BASE + 8'h02});
    check({ctrl_word, 8'(n_mode), 8'(n_done)}, {16'hABCD, 8'd1, 8'd1});
    want.push_back({16'h07DA, 32'h33});
    want.push_back({16'h03C7, 32'h0102});
    want.push_back({16'h03E9, 32'h11223344});
    send('{8'hE0, 8'h33, 8'h02, 8'h01, 8'h44, 8'h33, 8'h22, 8'h11}, 1'b0);
    finish_frame;
    check({mode, resp_id, ctrl_word}, {MODE_POSITION, TX_ID_BASE, 16'h0102});
    check({8'(n_mode), 8'(n_done)}, {8'd2, 8'd2});
  endtask

  task automatic scn_drop;
    send('{8'h5A, 8'h01, 8'h02}, 1'b0);
    finish_frame;
    send('{8'hE2, 8'h01}, 1'b0);
    finish_frame;
    check({8'(n_drop), 8'(n_mode), ctrl_word, mode}, {8'd2, 8'd2, 16'h0102, MODE_POSITION});
    // a short frame keeps the entries that completed but is flagged
    want.push_back({16'h07DA, 32'h01});
    want.push_back({16'h03C7, 32'h0302});
    send('{8'hE0, 8'h01, 8'h02, 8'h03}, 1'b0);
    finish_frame;
    check({8'(n_size), 8'(n_done), 8'(n_ctrl), ctrl_word}, {8'd1, 8'd2, 8'd3, 16'h0302});
  endtask

  task automatic scn_stall;
    @(negedge clk);
    wr_ready = 1'b0;
    for (int i = 1; i <= 10; i++) want.push_back({16'h05DC, 32'(i)});
    send('{8'hE3, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A}, 1'b0);
    repeat (20) @(negedge clk);
    check({rx_ready, wr_valid, wr_size}, {1'b0, 1'b1, 3'h1});
    wr_ready = 1'b1;
    finish_frame;
    check({mode, 8'(n_mode), 8'(n_done)}, {MODE_POSITION, 8'd2, 8'd3});
    check({resp_layout, resp_id, 8'(n_ctrl)}, {2'h3, TX_ID_BASE + 8'h03, 8'd3});
  endtask

  initial begin
    clk = 1'b0;
    {rst_n, cfg_valid, cfg_op, cfg_resp, cfg_layout, cfg_param, cfg_target, start, slow, frame, len} = '0;
    wr_ready = 1'b1;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    check({mode, resp_id, rx_ready}, {MODE_RESET, TX_ID_BASE, 1'b1});
    scn_config;
    scn_frames;
    scn_drop;
    scn_stall;
    close_out;
  end
endmodule
